// [cpu_regs_params.svh]
// Register indices, flag positions, reset values and widths for the CPU register file
`ifndef CPU_REGS_PARAMS_SVH
`define CPU_REGS_PARAMS_SVH
`define IDX_DATA_WORD_ZERO 5'h00
`define IDX_DATA_WORD_ONE 5'h01
`define IDX_DATA_WORD_TWO 5'h02
`define IDX_DATA_WORD_THREE 5'h03
`define IDX_ADDR_POINTER_ZERO 5'h04
`define IDX_ADDR_POINTER_ONE 5'h05
`define IDX_FRAME_BASE 5'h06
`define IDX_VECTOR_TABLE_BASE 5'h07
`define IDX_PROGRAM_COUNTER 5'h08
`define IDX_USER_STACK 5'h09
`define IDX_IRQ_STACK 5'h0A
`define IDX_STATIC_BASE 5'h0B
`define IDX_STATE_FLAGS 5'h0C
`define IDX_ACTIVE_STACK 5'h0D
`define IDX_DATA_ZERO_LOWER_BYTE 5'h10
`define IDX_DATA_ZERO_UPPER_BYTE 5'h11
`define IDX_DATA_ONE_LOWER_BYTE 5'h12
`define IDX_DATA_ONE_UPPER_BYTE 5'h13
`define IDX_DATA_PAIR_LOW_LONG 5'h14
`define IDX_DATA_PAIR_HIGH_LONG 5'h15
`define IDX_ADDR_POINTER_LONG 5'h16
`define FLAG_CARRY 0
`define FLAG_DEBUG 1
`define FLAG_ZERO 2
`define FLAG_SIGN 3
`define FLAG_BANK 4
`define FLAG_OVERFLOW 5
`define FLAG_IRQ_ENABLE 6
`define FLAG_STACK_SEL 7
`define RST_WORD 16'h0000
`define RST_WIDE 20'h0_0000
`define RST_FLAGS 11'h000
`define RST_READ 32'h0000_0000
`endif

// [cpu_regs_pkg.sv]
// Types shared by the CPU register file and its users
package cpu_regs_pkg;
	typedef enum logic [1:0] {
		size_byte = 2'h0,
		size_word = 2'h1,
		size_long = 2'h2
	} access_size_t;
	typedef struct packed {
		logic [31:0] result;
		access_size_t size;
		logic carry;
		logic overflow;
		logic set_carry;
		logic set_zero_sign;
		logic set_overflow;
	} alu_update_t;
endpackage

// [cpu_banked_register_file.sv]
// Banked CPU register set with byte, word and long views and a flag register
`timescale 1ns/10ps
`include "cpu_regs_params.svh"
module cpu_banked_register_file
	import cpu_regs_pkg::*;
#(
	parameter int DATA_W = 16,
	parameter int WIDE_W = 20,
	parameter int FLAG_W = 11
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic [4:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [31:0] reg_rdata_o,
	input wire alu_update_t alu_update_i,
	input wire logic pc_step_i,
	input wire logic [2:0] pc_step_len_i,
	input wire logic sp_adjust_i,
	input wire logic [15:0] sp_delta_i,
	output logic [19:0] program_counter_o,
	output logic [19:0] vector_table_base_o,
	output logic [15:0] active_stack_pointer_o,
	output logic [15:0] frame_base_pointer_o,
	output logic [15:0] static_base_pointer_o,
	output logic [10:0] cpu_state_flags_o
);

	// Banked storage, indexed by bank then register
	logic [DATA_W-1:0] data_reg [0:1][0:3];
	logic [DATA_W-1:0] addr_reg [0:1][0:1];
	logic [DATA_W-1:0] fb_reg [0:1];
	logic [DATA_W-1:0] fb_next [0:1];

	// Shared storage
	logic [WIDE_W-1:0] vector_table_base_reg;
	logic [WIDE_W-1:0] pc_reg;
	logic [WIDE_W-1:0] pc_next;
	logic [DATA_W-1:0] usp_reg;
	logic [DATA_W-1:0] usp_next;
	logic [DATA_W-1:0] isp_reg;
	logic [DATA_W-1:0] isp_next;
	logic [DATA_W-1:0] sb_reg;
	logic [FLAG_W-1:0] flg_reg;
	logic [FLAG_W-1:0] flg_next;

	// Mirrors of the currently selected registers
	logic [DATA_W-1:0] active_sp_reg;
	logic [DATA_W-1:0] fb_active_reg;

	// Read path
	logic [31:0] rdata_reg;
	logic [31:0] read_value;

	// Decoded strobes
	logic cur_bank;
	logic cur_stack;
	logic wr_sel_user;
	logic wr_sel_irq;

	// Replace one byte of a word, other byte kept
	function automatic logic [15:0] byte_merge(
		input logic [15:0] old_word,
		input logic [7:0] new_byte,
		input logic upper
	);
		logic [15:0] merged;
		merged = upper ? {new_byte, old_word[7:0]} : {old_word[15:8], new_byte};
		return merged;
	endfunction

	// Zero test of a result at its operand size
	function automatic logic result_zero(
		input logic [31:0] value,
		input access_size_t size
	);
		logic is_zero;
		is_zero = 1'b0;
		case (size)
			size_byte: is_zero = (value[7:0] == 8'h00);
			size_word: is_zero = (value[15:0] == 16'h0000);
			default: is_zero = (value == 32'h0000_0000);
		endcase
		return is_zero;
	endfunction

	// Sign bit of a result at its operand size
	function automatic logic result_negative(
		input logic [31:0] value,
		input access_size_t size
	);
		logic neg;
		neg = 1'b0;
		case (size)
			size_byte: neg = value[7];
			size_word: neg = value[15];
			default: neg = value[31];
		endcase
		return neg;
	endfunction

	// Bank and stack selection follow the stored flags
	assign cur_bank = flg_reg[`FLAG_BANK];
	assign cur_stack = flg_reg[`FLAG_STACK_SEL];

	// Which stack pointer a write lands in
	always_comb begin
		wr_sel_user = 1'b0;
		wr_sel_irq = 1'b0;
		if (reg_write_i) begin
			if (reg_addr_i == `IDX_USER_STACK) begin
				wr_sel_user = 1'b1;
			end else if (reg_addr_i == `IDX_IRQ_STACK) begin
				wr_sel_irq = 1'b1;
			end else if (reg_addr_i == `IDX_ACTIVE_STACK) begin
				wr_sel_user = ~cur_stack;
				wr_sel_irq = cur_stack;
			end
		end
	end

	// Data registers of the selected bank, byte, word and long views
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int b = 0; b < 2; b++) begin
				for (int r = 0; r < 4; r++) begin
					data_reg[b][r] <= `RST_WORD;
				end
			end
		end else if (reg_write_i) begin
			if (reg_addr_i == `IDX_DATA_WORD_ZERO) begin
				data_reg[cur_bank][0] <= reg_wdata_i[15:0];
			end else if (reg_addr_i == `IDX_DATA_WORD_ONE) begin
				data_reg[cur_bank][1] <= reg_wdata_i[15:0];
			end else if (reg_addr_i == `IDX_DATA_WORD_TWO) begin
				data_reg[cur_bank][2] <= reg_wdata_i[15:0];
			end else if (reg_addr_i == `IDX_DATA_WORD_THREE) begin
				data_reg[cur_bank][3] <= reg_wdata_i[15:0];
			end else if (reg_addr_i == `IDX_DATA_ZERO_LOWER_BYTE) begin
				data_reg[cur_bank][0] <= byte_merge(data_reg[cur_bank][0], reg_wdata_i[7:0], 1'b0);
			end else if (reg_addr_i == `IDX_DATA_ZERO_UPPER_BYTE) begin
				data_reg[cur_bank][0] <= byte_merge(data_reg[cur_bank][0], reg_wdata_i[7:0], 1'b1);
			end else if (reg_addr_i == `IDX_DATA_ONE_LOWER_BYTE) begin
				data_reg[cur_bank][1] <= byte_merge(data_reg[cur_bank][1], reg_wdata_i[7:0], 1'b0);
			end else if (reg_addr_i == `IDX_DATA_ONE_UPPER_BYTE) begin
				data_reg[cur_bank][1] <= byte_merge(data_reg[cur_bank][1], reg_wdata_i[7:0], 1'b1);
			end else if (reg_addr_i == `IDX_DATA_PAIR_LOW_LONG) begin
				data_reg[cur_bank][0] <= reg_wdata_i[15:0];
				data_reg[cur_bank][2] <= reg_wdata_i[31:16];
			end else if (reg_addr_i == `IDX_DATA_PAIR_HIGH_LONG) begin
				data_reg[cur_bank][1] <= reg_wdata_i[15:0];
				data_reg[cur_bank][3] <= reg_wdata_i[31:16];
			end
		end
	end

	// Address registers of the selected bank
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int b = 0; b < 2; b++) begin
				addr_reg[b][0] <= `RST_WORD;
				addr_reg[b][1] <= `RST_WORD;
			end
		end else if (reg_write_i) begin
			if (reg_addr_i == `IDX_ADDR_POINTER_ZERO) begin
				addr_reg[cur_bank][0] <= reg_wdata_i[15:0];
			end else if (reg_addr_i == `IDX_ADDR_POINTER_ONE) begin
				addr_reg[cur_bank][1] <= reg_wdata_i[15:0];
			end else if (reg_addr_i == `IDX_ADDR_POINTER_LONG) begin
				addr_reg[cur_bank][0] <= reg_wdata_i[15:0];
				addr_reg[cur_bank][1] <= reg_wdata_i[31:16];
			end
		end
	end

	// Next frame base of each bank
	always_comb begin
		fb_next[0] = fb_reg[0];
		fb_next[1] = fb_reg[1];
		if (reg_write_i && (reg_addr_i == `IDX_FRAME_BASE)) begin
			fb_next[cur_bank] = reg_wdata_i[15:0];
		end
	end

	// Frame base registers, one per bank
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fb_reg[0] <= `RST_WORD;
			fb_reg[1] <= `RST_WORD;
		end else begin
			fb_reg[0] <= fb_next[0];
			fb_reg[1] <= fb_next[1];
		end
	end

	// Frame base of the bank in force next cycle
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fb_active_reg <= `RST_WORD;
		end else begin
			fb_active_reg <= fb_next[flg_next[`FLAG_BANK]];
		end
	end

	// Vector table base, shared by both banks
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			vector_table_base_reg <= `RST_WIDE;
		end else if (reg_write_i && (reg_addr_i == `IDX_VECTOR_TABLE_BASE)) begin
			vector_table_base_reg <= reg_wdata_i[19:0];
		end
	end

	// Static base, shared by both banks
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sb_reg <= `RST_WORD;
		end else if (reg_write_i && (reg_addr_i == `IDX_STATIC_BASE)) begin
			sb_reg <= reg_wdata_i[15:0];
		end
	end

	// Program counter: a load wins over a step
	always_comb begin
		pc_next = pc_reg;
		if (reg_write_i && (reg_addr_i == `IDX_PROGRAM_COUNTER)) begin
			pc_next = reg_wdata_i[19:0];
		end else if (pc_step_i) begin
			pc_next = pc_reg + {17'h0_0000, pc_step_len_i};
		end
	end

	// Program counter register
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pc_reg <= `RST_WIDE;
		end else begin
			pc_reg <= pc_next;
		end
	end

	// Stack pointers: a write wins over an adjust of the active one
	always_comb begin
		usp_next = usp_reg;
		isp_next = isp_reg;
		if (wr_sel_user) begin
			usp_next = reg_wdata_i[15:0];
		end else if (sp_adjust_i && !cur_stack) begin
			usp_next = usp_reg + sp_delta_i;
		end
		if (wr_sel_irq) begin
			isp_next = reg_wdata_i[15:0];
		end else if (sp_adjust_i && cur_stack) begin
			isp_next = isp_reg + sp_delta_i;
		end
	end

	// Stack pointer registers, shared by both banks
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			usp_reg <= `RST_WORD;
			isp_reg <= `RST_WORD;
		end else begin
			usp_reg <= usp_next;
			isp_reg <= isp_next;
		end
	end

	// Active stack pointer under next cycle's select flag
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			active_sp_reg <= `RST_WORD;
		end else if (flg_next[`FLAG_STACK_SEL]) begin
			active_sp_reg <= isp_next;
		end else begin
			active_sp_reg <= usp_next;
		end
	end

	// Flags: a direct write wins over the arithmetic unit
	always_comb begin
		flg_next = flg_reg;
		if (reg_write_i && (reg_addr_i == `IDX_STATE_FLAGS)) begin
			flg_next = reg_wdata_i[10:0];
		end else begin
			if (alu_update_i.set_carry) begin
				flg_next[`FLAG_CARRY] = alu_update_i.carry;
			end
			if (alu_update_i.set_zero_sign) begin
				flg_next[`FLAG_ZERO] = result_zero(alu_update_i.result, alu_update_i.size);
				flg_next[`FLAG_SIGN] = result_negative(alu_update_i.result, alu_update_i.size);
			end
			if (alu_update_i.set_overflow) begin
				flg_next[`FLAG_OVERFLOW] = alu_update_i.overflow;
			end
		end
	end

	// Flag register
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flg_reg <= `RST_FLAGS;
		end else begin
			flg_reg <= flg_next;
		end
	end

	// Read selection from the current bank and shared set
	always_comb begin
		read_value = 32'h0000_0000;
		if (reg_addr_i == `IDX_DATA_WORD_ZERO) begin
			read_value = {16'h0000, data_reg[cur_bank][0]};
		end else if (reg_addr_i == `IDX_DATA_WORD_ONE) begin
			read_value = {16'h0000, data_reg[cur_bank][1]};
		end else if (reg_addr_i == `IDX_DATA_WORD_TWO) begin
			read_value = {16'h0000, data_reg[cur_bank][2]};
		end else if (reg_addr_i == `IDX_DATA_WORD_THREE) begin
			read_value = {16'h0000, data_reg[cur_bank][3]};
		end else if (reg_addr_i == `IDX_ADDR_POINTER_ZERO) begin
			read_value = {16'h0000, addr_reg[cur_bank][0]};
		end else if (reg_addr_i == `IDX_ADDR_POINTER_ONE) begin
			read_value = {16'h0000, addr_reg[cur_bank][1]};
		end else if (reg_addr_i == `IDX_FRAME_BASE) begin
			read_value = {16'h0000, fb_reg[cur_bank]};
		end else if (reg_addr_i == `IDX_VECTOR_TABLE_BASE) begin
			read_value = {12'h000, vector_table_base_reg};
		end else if (reg_addr_i == `IDX_PROGRAM_COUNTER) begin
			read_value = {12'h000, pc_reg};
		end else if (reg_addr_i == `IDX_USER_STACK) begin
			read_value = {16'h0000, usp_reg};
		end else if (reg_addr_i == `IDX_IRQ_STACK) begin
			read_value = {16'h0000, isp_reg};
		end else if (reg_addr_i == `IDX_STATIC_BASE) begin
			read_value = {16'h0000, sb_reg};
		end else if (reg_addr_i == `IDX_STATE_FLAGS) begin
			read_value = {21'h00_0000, flg_reg};
		end else if (reg_addr_i == `IDX_ACTIVE_STACK) begin
			read_value = {16'h0000, cur_stack ? isp_reg : usp_reg};
		end else if (reg_addr_i == `IDX_DATA_ZERO_LOWER_BYTE) begin
			read_value = {24'h00_0000, data_reg[cur_bank][0][7:0]};
		end else if (reg_addr_i == `IDX_DATA_ZERO_UPPER_BYTE) begin
			read_value = {24'h00_0000, data_reg[cur_bank][0][15:8]};
		end else if (reg_addr_i == `IDX_DATA_ONE_LOWER_BYTE) begin
			read_value = {24'h00_0000, data_reg[cur_bank][1][7:0]};
		end else if (reg_addr_i == `IDX_DATA_ONE_UPPER_BYTE) begin
			read_value = {24'h00_0000, data_reg[cur_bank][1][15:8]};
		end else if (reg_addr_i == `IDX_DATA_PAIR_LOW_LONG) begin
			read_value = {data_reg[cur_bank][2], data_reg[cur_bank][0]};
		end else if (reg_addr_i == `IDX_DATA_PAIR_HIGH_LONG) begin
			read_value = {data_reg[cur_bank][3], data_reg[cur_bank][1]};
		end else if (reg_addr_i == `IDX_ADDR_POINTER_LONG) begin
			read_value = {addr_reg[cur_bank][1], addr_reg[cur_bank][0]};
		end
	end

	// Read data stands one cycle after the strobe, zero otherwise
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_reg <= `RST_READ;
		end else begin
			rdata_reg <= reg_read_i ? read_value : `RST_READ;
		end
	end

	// Outputs, each straight from a flop
	assign reg_rdata_o = rdata_reg;
	assign program_counter_o = pc_reg;
	assign vector_table_base_o = vector_table_base_reg;
	assign active_stack_pointer_o = active_sp_reg;
	assign frame_base_pointer_o = fb_active_reg;
	assign static_base_pointer_o = sb_reg;
	assign cpu_state_flags_o = flg_reg;

endmodule

// [cpu_regs_chk.sv]
// Port-level checker for the banked CPU register file
`timescale 1ns/10ps
`include "cpu_regs_params.svh"
module cpu_regs_chk
	import cpu_regs_pkg::*;
(
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic [4:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	input wire logic [31:0] reg_rdata_o,
	input wire alu_update_t alu_update_i,
	input wire logic pc_step_i,
	input wire logic [2:0] pc_step_len_i,
	input wire logic sp_adjust_i,
	input wire logic [15:0] sp_delta_i,
	input wire logic [19:0] program_counter_o,
	input wire logic [19:0] vector_table_base_o,
	input wire logic [15:0] active_stack_pointer_o,
	input wire logic [15:0] frame_base_pointer_o,
	input wire logic [15:0] static_base_pointer_o,
	input wire logic [10:0] cpu_state_flags_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	// Write decode for the loads that win over other updates
	logic flag_wr;
	logic pc_wr;
	assign flag_wr = reg_write_i && reg_addr_i == `IDX_STATE_FLAGS;
	assign pc_wr = reg_write_i && reg_addr_i == `IDX_PROGRAM_COUNTER;
	// Read data only in the cycle after a read strobe
	chk_read_idle: assert property (!$past(reg_read_i) |-> reg_rdata_o == 32'h0000_0000)
		else $error("read data not zero outside read answer");
	chk_pc_step: assert property (pc_step_i && !pc_wr |=>
		program_counter_o == $past(program_counter_o) + 20'($past(pc_step_len_i)))
		else $error("program counter step wrong");
	chk_pc_load: assert property (pc_wr |=> program_counter_o == $past(reg_wdata_i[19:0]))
		else $error("program counter load wrong");
	chk_pc_hold: assert property (!pc_step_i && !reg_write_i |=> $stable(program_counter_o))
		else $error("program counter moved without cause");
	chk_vbase_load: assert property (reg_write_i && reg_addr_i == `IDX_VECTOR_TABLE_BASE |=>
		vector_table_base_o == $past(reg_wdata_i[19:0]))
		else $error("vector base load wrong");
	chk_flag_load: assert property (flag_wr |=> cpu_state_flags_o == $past(reg_wdata_i[10:0]))
		else $error("flag register load wrong");
	chk_carry_flag: assert property (alu_update_i.set_carry && !flag_wr |=>
		cpu_state_flags_o[0] == $past(alu_update_i.carry))
		else $error("carry flag wrong");
	chk_ovf_flag: assert property (alu_update_i.set_overflow && !flag_wr |=>
		cpu_state_flags_o[5] == $past(alu_update_i.overflow))
		else $error("overflow flag wrong");
	chk_word_zs: assert property (alu_update_i.set_zero_sign && alu_update_i.size == size_word && !flag_wr |=>
		cpu_state_flags_o[2] == ($past(alu_update_i.result[15:0]) == 16'h0000)
		&& cpu_state_flags_o[3] == $past(alu_update_i.result[15]))
		else $error("word zero or sign flag wrong");
	chk_long_sign: assert property (alu_update_i.set_zero_sign && alu_update_i.size == size_long && !flag_wr |=>
		cpu_state_flags_o[3] == $past(alu_update_i.result[31]))
		else $error("long sign flag wrong");
	// Main scenarios reached
	cover property (flag_wr && reg_wdata_i[4]);
	cover property (alu_update_i.set_zero_sign && alu_update_i.size == size_byte);
	cover property (pc_step_i);
	cover property (sp_adjust_i && cpu_state_flags_o[7]);
endmodule
bind cpu_banked_register_file cpu_regs_chk u_cpu_regs_chk (.clock_i(clock_i), .resetn_i(resetn_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
	.reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .alu_update_i(alu_update_i),
	.pc_step_i(pc_step_i), .pc_step_len_i(pc_step_len_i), .sp_adjust_i(sp_adjust_i),
	.sp_delta_i(sp_delta_i), .program_counter_o(program_counter_o),
	.vector_table_base_o(vector_table_base_o), .active_stack_pointer_o(active_stack_pointer_o),
	.frame_base_pointer_o(frame_base_pointer_o), .static_base_pointer_o(static_base_pointer_o),
	.cpu_state_flags_o(cpu_state_flags_o));

// [cpu_alu_model.sv]
// Behavioural decoder and arithmetic unit feeding the register file
`timescale 1ns/10ps
module cpu_alu_model
	import cpu_regs_pkg::*;
(
	input wire logic clock_i,
	output alu_update_t alu_update_o,
	output logic pc_step_o,
	output logic [2:0] pc_step_len_o,
	output logic sp_adjust_o,
	output logic [15:0] sp_delta_o
);
	// Idle at time zero
	initial begin
		alu_update_o = '0;
		pc_step_o = 1'b0;
		pc_step_len_o = 3'h0;
		sp_adjust_o = 1'b0;
		sp_delta_o = 16'h0000;
	end
	// One flag update pulse; the result lines then show junk, not the old value
	task automatic alu(input logic [31:0] r, input access_size_t s, input logic c, input logic o);
		@(posedge clock_i);
		alu_update_o <= '{r, s, c, o, 1'b1, 1'b1, 1'b1};
		@(posedge clock_i);
		alu_update_o <= '{~r, s, ~c, ~o, 1'b0, 1'b0, 1'b0};
		#1;
	endtask
	// Advance past one instruction
	task automatic step(input logic [2:0] len);
		@(posedge clock_i);
		pc_step_o <= 1'b1;
		pc_step_len_o <= len;
		@(posedge clock_i);
		pc_step_o <= 1'b0;
		pc_step_len_o <= ~len;
		#1;
	endtask
	// Push or pop on the active stack
	task automatic adjust(input logic [15:0] d);
		@(posedge clock_i);
		sp_adjust_o <= 1'b1;
		sp_delta_o <= d;
		@(posedge clock_i);
		sp_adjust_o <= 1'b0;
		sp_delta_o <= ~d;
		#1;
	endtask
endmodule

// [cpu_banked_register_file_test.sv]
// Self-checking bench for the banked CPU register file
`timescale 1ns/10ps
`include "cpu_regs_params.svh"
module cpu_banked_register_file_test
	import cpu_regs_pkg::*;
;
	logic clock_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [4:0] reg_addr_i = 5'h00;
	logic [31:0] reg_wdata_i = 32'h0000_0000;
	logic reg_write_i = 1'b0;
	logic reg_read_i = 1'b0;
	logic [31:0] reg_rdata_o;
	alu_update_t alu_w;
	logic pc_step_w;
	logic [2:0] pc_len_w;
	logic sp_adj_w;
	logic [15:0] sp_delta_w;
	logic [19:0] program_counter_o;
	logic [19:0] vector_table_base_o;
	logic [15:0] active_stack_pointer_o;
	logic [15:0] frame_base_pointer_o;
	logic [15:0] static_base_pointer_o;
	logic [10:0] cpu_state_flags_o;
	int num_errors = 0;
	int checks_done = 0;
	// Flag cases: result, size, carry and overflow in, flags expected
	logic [31:0] res_tab [5] = '{32'h0001_0000, 32'h0000_8000, 32'h0000_0180, 32'h8000_0000, 32'h0000_0100};
	access_size_t size_tab [5] = '{size_word, size_word, size_byte, size_long, size_byte};
	logic [1:0] co_tab [5] = '{2'h2, 2'h1, 2'h3, 2'h0, 2'h0};
	logic [10:0] flag_tab [5] = '{11'h005, 11'h028, 11'h029, 11'h008, 11'h004};
	cpu_banked_register_file u_cpu_banked_register_file (.clock_i(clock_i), .resetn_i(resetn_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
		.reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .alu_update_i(alu_w),
		.pc_step_i(pc_step_w), .pc_step_len_i(pc_len_w), .sp_adjust_i(sp_adj_w), .sp_delta_i(sp_delta_w),
		.program_counter_o(program_counter_o), .vector_table_base_o(vector_table_base_o),
		.active_stack_pointer_o(active_stack_pointer_o), .frame_base_pointer_o(frame_base_pointer_o),
		.static_base_pointer_o(static_base_pointer_o), .cpu_state_flags_o(cpu_state_flags_o));
	cpu_alu_model u_cpu_alu_model (.clock_i(clock_i), .alu_update_o(alu_w), .pc_step_o(pc_step_w),
		.pc_step_len_o(pc_len_w), .sp_adjust_o(sp_adj_w), .sp_delta_o(sp_delta_w));
	// 100 MHz clock
	always #5 clock_i = ~clock_i;
	// Compare and count
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One-cycle register write
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_write_i <= 1'b1;
		@(posedge clock_i);
		reg_write_i <= 1'b0;
		#1;
	endtask
	// One-cycle register read, data taken in the following cycle
	task automatic rd(input logic [4:0] a, input logic [31:0] exp);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_read_i <= 1'b1;
		@(posedge clock_i);
		reg_read_i <= 1'b0;
		#1;
		cmp(reg_rdata_o, exp);
	endtask
	// Verdict and end of run
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Hang guard
	initial begin
		#100000;
		num_errors++;
		wrap_up();
	end
	// Test sequence
	initial begin
		repeat (8) @(posedge clock_i);
		resetn_i <= 1'b1;
		for (int i = 0; i < 32; i++) begin
			rd(5'(i), 32'h0000_0000);
		end
		$display("test reset done");
		for (int b = 0; b < 2; b++) begin
			wr(`IDX_STATE_FLAGS, 32'(b) << 4);
			for (int i = 0; i < 7; i++) begin
				wr(5'(i), 32'(32'h0000_1000 * (b + 1) + i));
			end
		end
		wr(`IDX_STATIC_BASE, 32'h0000_5A5A);
		for (int b = 0; b < 2; b++) begin
			wr(`IDX_STATE_FLAGS, 32'(b) << 4);
			for (int i = 0; i < 7; i++) begin
				rd(5'(i), 32'(32'h0000_1000 * (b + 1) + i));
			end
			cmp(32'(frame_base_pointer_o), 32'(32'h0000_1006 + 32'h0000_1000 * b));
			rd(`IDX_STATIC_BASE, 32'h0000_5A5A);
			cmp(32'(static_base_pointer_o), 32'h0000_5A5A);
		end
		$display("test banks done");
		wr(`IDX_DATA_WORD_ZERO, 32'h0000_1234);
		wr(`IDX_DATA_ZERO_LOWER_BYTE, 32'h0000_FFAB);
		rd(`IDX_DATA_WORD_ZERO, 32'h0000_12AB);
		wr(`IDX_DATA_ZERO_UPPER_BYTE, 32'h0000_00CD);
		rd(`IDX_DATA_WORD_ZERO, 32'h0000_CDAB);
		rd(`IDX_DATA_ZERO_UPPER_BYTE, 32'h0000_00CD);
		wr(`IDX_DATA_ONE_UPPER_BYTE, 32'h0000_0077);
		rd(`IDX_DATA_ONE_LOWER_BYTE, 32'h0000_0001);
		rd(`IDX_DATA_WORD_ONE, 32'h0000_7701);
		wr(`IDX_DATA_PAIR_LOW_LONG, 32'h89AB_CDEF);
		rd(`IDX_DATA_WORD_TWO, 32'h0000_89AB);
		rd(`IDX_DATA_WORD_ZERO, 32'h0000_CDEF);
		wr(`IDX_DATA_PAIR_HIGH_LONG, 32'h1357_2468);
		rd(`IDX_DATA_WORD_THREE, 32'h0000_1357);
		rd(`IDX_DATA_WORD_ONE, 32'h0000_2468);
		wr(`IDX_ADDR_POINTER_LONG, 32'hBEEF_0042);
		rd(`IDX_ADDR_POINTER_ONE, 32'h0000_BEEF);
		rd(`IDX_ADDR_POINTER_ZERO, 32'h0000_0042);
		rd(`IDX_ADDR_POINTER_LONG, 32'hBEEF_0042);
		$display("test views done");
		wr(`IDX_VECTOR_TABLE_BASE, 32'hFFFF_FFFF);
		cmp(32'(vector_table_base_o), 32'h000F_FFFF);
		rd(`IDX_VECTOR_TABLE_BASE, 32'h000F_FFFF);
		wr(`IDX_PROGRAM_COUNTER, 32'h000F_FFFE);
		u_cpu_alu_model.step(3'h5);
		cmp(32'(program_counter_o), 32'h0000_0003);
		$display("test wide done");
		wr(`IDX_STATE_FLAGS, 32'h0000_0000);
		wr(`IDX_USER_STACK, 32'h0000_1000);
		wr(`IDX_IRQ_STACK, 32'h0000_2000);
		cmp(32'(active_stack_pointer_o), 32'h0000_1000);
		wr(`IDX_STATE_FLAGS, 32'h0000_0080);
		cmp(32'(active_stack_pointer_o), 32'h0000_2000);
		u_cpu_alu_model.adjust(16'hFFFE);
		rd(`IDX_ACTIVE_STACK, 32'h0000_1FFE);
		rd(`IDX_USER_STACK, 32'h0000_1000);
		wr(`IDX_ACTIVE_STACK, 32'h0000_3000);
		rd(`IDX_IRQ_STACK, 32'h0000_3000);
		wr(`IDX_STATE_FLAGS, 32'h0000_0000);
		u_cpu_alu_model.adjust(16'h0002);
		cmp(32'(active_stack_pointer_o), 32'h0000_1002);
		$display("test stacks done");
		wr(`IDX_STATE_FLAGS, 32'h0000_0000);
		for (int i = 0; i < 5; i++) begin
			u_cpu_alu_model.alu(res_tab[i], size_tab[i], co_tab[i][1], co_tab[i][0]);
			rd(`IDX_STATE_FLAGS, 32'(flag_tab[i]));
		end
		wr(`IDX_STATE_FLAGS, 32'hFFFF_F7FD);
		rd(`IDX_STATE_FLAGS, 32'h0000_07FD);
		cmp(32'(cpu_state_flags_o), 32'h0000_07FD);
		$display("test flags done");
		wrap_up();
	end
endmodule
